// ===== rtl/ddsp_port.sv
// Purpose: serial diagnostic port, mode register and output protection of a quad driver
// Assumes: pins and analog comparator levels come from outside mclk and pass two
//          flip-flops before any logic reads them
// Notes: serial clock is sampled, never used as a clock
`include "ddsp_params.svh"
module ddsp_port #(
   parameter int unsigned LONG_DLY_CYC = `DDSP_DLY_LONG_NS / `DDSP_CLK_NS,
   parameter int unsigned SHORT_DLY_CYC = `DDSP_DLY_SHORT_NS / `DDSP_CLK_NS,
   parameter int unsigned SG_DLY_CYC = `DDSP_SG_DLY_NS / `DDSP_CLK_NS
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic csN,
   input wire logic sclk,
   input wire logic readNotWrite,
   input wire logic dataIn,
   output logic dataOut,
   output logic dataOe,
   input wire logic [3:0] driveInputsN,
   input wire logic [3:0] overTempSense,
   input wire logic [3:0] overCurrentHi,
   input wire logic [1:0] overCurrentLo,
   input wire logic [3:0] lowLoadCmp,
   input wire logic [3:0] groundShortCmp,
   output logic [3:0] powerOutputs,
   output logic testMode,
   output logic currentLimitSelect
);
   logic [6:0] s1_r, s2_r, s3_r;
   logic csS, clkS, rwS, dS, csPrev, clkPrev;
   logic csFall, csRise, clkFall, clkRise;
   ddsp_pkg::ddsp_phase_t phase_r;
   logic [`DDSP_SHIFT_W-1:0] shift_r;
   logic [`DDSP_WORD_W-1:0] diag_r;
   logic [`DDSP_MODE_W-1:0] mode_r, wsh_r;
   logic firstFall_r;
   logic [3:0] latchOff_r, onPrev_r;
   logic [3:0] olFlt, sgFlt;
   logic [3:0] scNow;
   logic [31:0] olCnt_r [4];
   logic [31:0] sgCnt_r [4];
   logic [3:0] driveOn;
   logic [17:0] cmpS1_r, cmpS2_r;
   logic [3:0] tmpS, ocHiS, olS, sgS;
   logic [1:0] ocLoS;

   always_ff @(posedge mclk) begin
      s1_r <= {dataIn, readNotWrite, sclk, csN, driveInputsN[3:1]};
      s2_r <= s1_r;
   end
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s3_r <= 7'h7f;
      end else begin
         s3_r <= s2_r;
      end
   end
   // driveInputsN[0] synchronised separately below
   logic [1:0] in0_r;
   always_ff @(posedge mclk) begin
      in0_r <= {in0_r[0], driveInputsN[0]};
   end
   // comparators switch on their own time; two flops keep a half-set trip bit out
   always_ff @(posedge mclk) begin
      cmpS1_r <= {overTempSense, overCurrentHi, overCurrentLo, lowLoadCmp, groundShortCmp};
      cmpS2_r <= cmpS1_r;
   end
   assign {tmpS, ocHiS, ocLoS, olS, sgS} = cmpS2_r;
   assign {dS, rwS, clkS, csS} = s2_r[6:3];
   assign csPrev = s3_r[3];
   assign clkPrev = s3_r[4];
   assign csFall = csPrev && !csS;
   assign csRise = !csPrev && csS;
   assign clkFall = clkPrev && !clkS && !csS;
   assign clkRise = !clkPrev && clkS && !csS;
   assign driveOn = ~{s2_r[2:0], in0_r[1]};

   // frame phase; direction may drop after the fall to turn a read into a write
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         phase_r <= ddsp_pkg::DDSP_IDLE;
      end else if (csRise) begin
         phase_r <= ddsp_pkg::DDSP_IDLE;
      end else if (csFall && clkS) begin
         phase_r <= ddsp_pkg::DDSP_READ;
      end else if (phase_r != ddsp_pkg::DDSP_IDLE && !rwS) begin
         phase_r <= ddsp_pkg::DDSP_WRITE;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         shift_r <= '0;
         dataOut <= 1'b0;
      end else if (csFall && clkS) begin
         shift_r <= diag_r[`DDSP_WORD_W-1:1];
         dataOut <= |diag_r[`DDSP_WORD_W-1:1];
      end else if (clkRise && phase_r == ddsp_pkg::DDSP_READ) begin
         shift_r <= {1'b0, shift_r[`DDSP_SHIFT_W-1:1]};
         dataOut <= shift_r[0];
      end
   end

   // pin turns to input when direction is low
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         dataOe <= 1'b0;
      end else begin
         dataOe <= !csS && rwS && (phase_r == ddsp_pkg::DDSP_READ || (csFall && clkS));
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         wsh_r <= '0;
      end else if (clkFall && phase_r == ddsp_pkg::DDSP_WRITE) begin
         wsh_r <= {wsh_r[`DDSP_MODE_W-2:0], dS};
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         mode_r <= `DDSP_MODE_RESET;
      end else if (csRise && phase_r == ddsp_pkg::DDSP_WRITE) begin
         mode_r <= wsh_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         testMode <= 1'b0;
         currentLimitSelect <= 1'b0;
      end else begin
         testMode <= mode_r[`DDSP_MODE_TEST];
         currentLimitSelect <= mode_r[`DDSP_MODE_ISC];
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         firstFall_r <= 1'b0;
      end else if (csFall) begin
         firstFall_r <= 1'b1;
      end else if (clkFall || csRise) begin
         firstFall_r <= 1'b0;
      end
   end

   // lower threshold on outputs 3 and 4
   assign scNow = {mode_r[`DDSP_MODE_ISC] ? ocLoS[1] : ocHiS[3],
      mode_r[`DDSP_MODE_ISC] ? ocLoS[0] : ocHiS[2], ocHiS[1:0]};

   // open-load and ground-short filters
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 4; i++) begin
         if (!resetn || !(driveOn[i] && powerOutputs[i] && olS[i])) begin
            olCnt_r[i] <= '0;
         end else if (!olFlt[i]) begin
            olCnt_r[i] <= olCnt_r[i] + 32'h1;
         end
         if (!resetn || !sgS[i]) begin
            sgCnt_r[i] <= '0;
         end else if (!sgFlt[i]) begin
            sgCnt_r[i] <= sgCnt_r[i] + 32'h1;
         end
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         olFlt[i] = olCnt_r[i] >= (mode_r[i] ? SHORT_DLY_CYC : LONG_DLY_CYC);
         sgFlt[i] = sgCnt_r[i] >= SG_DLY_CYC;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         latchOff_r <= '0;
         onPrev_r <= '0;
         powerOutputs <= '0;
      end else begin
         onPrev_r <= driveOn;
         for (int i = 0; i < 4; i++) begin
            if (powerOutputs[i] && scNow[i]) begin
               latchOff_r[i] <= 1'b1;
            end else if (driveOn[i] && !onPrev_r[i]) begin
               latchOff_r[i] <= 1'b0;
            end
         end
         powerOutputs <= driveOn & ~latchOff_r & ~(powerOutputs & scNow);
      end
   end

   // clear on first fall; set wins over clear
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         diag_r <= '0;
      end else begin
         if (clkFall && firstFall_r && phase_r == ddsp_pkg::DDSP_READ) begin
            diag_r <= '0;
         end
         if (|tmpS) begin
            diag_r[`DDSP_POS_TMP+1] <= 1'b1;
         end
         for (int i = 0; i < 4; i++) begin
            if (powerOutputs[i] && scNow[i]) begin
               diag_r[`DDSP_POS_SC+1+i] <= 1'b1;
            end
            if (olFlt[i]) begin
               diag_r[`DDSP_POS_OL+1+i] <= 1'b1;
            end
            if (sgFlt[i]) begin
               diag_r[`DDSP_POS_SG+1+i] <= 1'b1;
            end
         end
         diag_r[`DDSP_WORD_W-1 -: 8] <= {sgS, olS};
      end
   end

   // bit 0 of the word is summary only
   property p_sum;
      @(posedge mclk) disable iff (!resetn)
      (csFall && clkS) |=> (dataOut == |$past(diag_r[`DDSP_WORD_W-1:1]));
   endproperty
   a_sum: assert property (p_sum) else $error("summary wrong");
   property p_oe;
      @(posedge mclk) disable iff (!resetn)
      (!rwS) |=> !dataOe;
   endproperty
   a_oe: assert property (p_oe) else $error("pin driven in write");
   property p_mode;
      @(posedge mclk) disable iff (!resetn)
      !(csRise && phase_r == ddsp_pkg::DDSP_WRITE) |=> $stable(mode_r);
   endproperty
   a_mode: assert property (p_mode) else $error("mode changed outside store");
   property p_store;
      @(posedge mclk) disable iff (!resetn)
      (csRise && phase_r == ddsp_pkg::DDSP_WRITE) |=> (mode_r == $past(wsh_r));
   endproperty
   a_store: assert property (p_store) else $error("store lost");
   property p_off;
      @(posedge mclk) disable iff (!resetn)
      (|(powerOutputs & scNow)) |=> ((powerOutputs & $past(powerOutputs & scNow)) == 4'h0)
         ##1 ((powerOutputs & $past(powerOutputs & scNow, 2)) == 4'h0);
   endproperty
   a_off: assert property (p_off) else $error("short not latched");
   property p_tmp;
      @(posedge mclk) disable iff (!resetn)
      (|tmpS) |=> diag_r[`DDSP_POS_TMP+1];
   endproperty
   a_tmp: assert property (p_tmp) else $error("overtemp missed");
   property p_fill;
      @(posedge mclk) disable iff (!resetn)
      (clkRise && phase_r == ddsp_pkg::DDSP_READ) |=>
         (shift_r == {1'b0, $past(shift_r[`DDSP_SHIFT_W-1:1])});
   endproperty
   a_fill: assert property (p_fill) else $error("fill not zero");
   property p_shift;
      @(posedge mclk) disable iff (!resetn)
      (clkRise && phase_r == ddsp_pkg::DDSP_READ) |=> (dataOut == $past(shift_r[0]));
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");
   property p_rst;
      @(posedge mclk) !resetn |=> (powerOutputs == 4'h0 && mode_r == `DDSP_MODE_RESET);
   endproperty
   a_rst: assert property (p_rst) else $error("reset not applied");
   property p_load;
      @(posedge mclk) disable iff (!resetn)
      (csFall && clkS) |=> (shift_r == $past(diag_r[`DDSP_WORD_W-1:1]));
   endproperty
   a_load: assert property (p_load) else $error("shifter not loaded");
   property p_drive;
      @(posedge mclk) disable iff (!resetn)
      (csFall && clkS && rwS) |=> dataOe;
   endproperty
   a_drive: assert property (p_drive) else $error("pin not driven on read");
   property p_clr;
      @(posedge mclk) disable iff (!resetn)
      (clkFall && firstFall_r && phase_r == ddsp_pkg::DDSP_READ && !(|tmpS)) |=>
         !diag_r[`DDSP_POS_TMP+1];
   endproperty
   a_clr: assert property (p_clr) else $error("word not cleared");
   property p_wshift;
      @(posedge mclk) disable iff (!resetn)
      (clkFall && phase_r == ddsp_pkg::DDSP_WRITE) |=> (wsh_r[0] == $past(dS));
   endproperty
   a_wshift: assert property (p_wshift) else $error("write bit not taken");
   property p_sc;
      @(posedge mclk) disable iff (!resetn)
      (|(powerOutputs & scNow)) |=> ((diag_r[`DDSP_POS_SC+4:`DDSP_POS_SC+1] &
         $past(powerOutputs & scNow)) == $past(powerOutputs & scNow));
   endproperty
   a_sc: assert property (p_sc) else $error("short bit missed");
endmodule : ddsp_port

// ===== rtl/ddsp_params.svh
// Purpose: constants for the driver diagnostic serial port
// Assumes: one system clock mclk at 200 MHz, serial pins sampled into it
// Notes: bit positions of the filtered fault fields are a mapping that can be moved here
// Summary of operation
// - cs fall with clock high loads shifter
// - cs fall drives data pin with summary
// - first clock fall clears diagnostic word
// - each clock rise shifts next bit out
// - overtemp flag ORs sensors, outputs stay on
// - short sets bit, latches driver off
// - low current while on sets open-load
// - low pin voltage sets ground-short bit
// - top eight bits hold raw comparators
// - direction low: six-bit write, pin input
// - first write bit sampled first clock fall
// - write store updates on cs rise only
// - reset restores mode register defaults
// - defaults all zero in mode register
// - reset holds outputs off, state cleared
// - write keeps diagnostics, read keeps mode
// - test bit high selects test mode
// - limit select high picks lower threshold
// - delay select high picks shorter delay
// - word is summary plus 21 shifted bits
// - shifter serial input low, trailing zeros
`ifndef DDSP_PARAMS_SVH
`define DDSP_PARAMS_SVH
`define DDSP_WORD_W 22
`define DDSP_SHIFT_W 21
`define DDSP_MODE_W 6
`define DDSP_MODE_RESET 6'h00
`define DDSP_POS_TMP 0
`define DDSP_POS_SC 1
`define DDSP_POS_OL 5
`define DDSP_POS_SG 9
`define DDSP_POS_RAW_OL 13
`define DDSP_POS_RAW_SG 17
`define DDSP_MODE_TEST 5
`define DDSP_MODE_ISC 4
`define DDSP_DLY_LONG_NS 5200000
`define DDSP_DLY_SHORT_NS 3000000
`define DDSP_CLK_NS 5
`define DDSP_SG_DLY_NS 10000
`endif

// ===== rtl/ddsp_pkg.sv
// Purpose: types for the driver diagnostic serial port
// Assumes: nothing beyond the params header
// Notes: serial phase of the current frame
package ddsp_pkg;
   typedef enum logic [1:0] {
      DDSP_IDLE = 2'b00,
      DDSP_READ = 2'b01,
      DDSP_WRITE = 2'b10
   } ddsp_phase_t;
endpackage : ddsp_pkg

// ===== verif/ddsp_host.sv
// Purpose: host model that runs frames on the serial port
// Assumes: sclk idles high and runs at 48 ns inside frames
// Notes: a released data pin shows a toggling pattern
module ddsp_host (
   output logic csN,
   output logic sclk,
   output logic readNotWrite,
   output logic dataIn,
   input wire logic dataOut,
   input wire logic dataOe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic hostBit = 1'b0;
   logic hostOe = 1'b0;
   logic junk = 1'b0;
   logic [23:0] rdWord;
   always #3 junk = ~junk;
   // both ends driving at once reads as unknown
   assign dataIn = dataOe ? (hostOe ? 1'bx : dataOut) : (hostOe ? hostBit : junk);
   initial begin
      csN = 1'b1;
      sclk = 1'b1;
      readNotWrite = 1'b1;
   end
   task automatic frame(input logic rd, input int n, input logic [7:0] wr);
      readNotWrite = rd;
      hostOe = !rd;
      hostBit = wr[7];
      #48;
      csN = 1'b0;
      #48;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         #24;
         rdWord[i] = dataIn;
         sclk = 1'b1;
         #12;
         wr = wr << 1;
         hostBit = wr[7];
         #12;
      end
      csN = 1'b1;
      #48;
      hostOe = 1'b0;
      readNotWrite = 1'b1;
   endtask : frame
endmodule : ddsp_host

// ===== verif/test_driver_diag_serial_port.sv
// Purpose: self-checking bench of the diagnostic serial port
// Assumes: filter counts shortened to 20, 10 and 5 cycles
// Notes: expected results queue up, a monitor compares them in order
module test_driver_diag_serial_port;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {int kind; logic [23:0] exp;} ddsp_note_t;
   ddsp_note_t notes[$];
   ddsp_note_t nt;
   event look;
   int num_errors = 0;
   int num_checks = 0;
   int seed = 32'h3ef32328;
   logic [31:0] v;
   logic [3:0] ot, sg;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic csN, sclk, readNotWrite, dataIn, dataOut, dataOe, testMode, currentLimitSelect;
   logic [3:0] driveInputsN = 4'hf;
   logic [3:0] overTempSense = 4'h0;
   logic [3:0] overCurrentHi = 4'h0;
   logic [1:0] overCurrentLo = 2'h0;
   logic [3:0] lowLoadCmp = 4'h0;
   logic [3:0] groundShortCmp = 4'h0;
   logic [3:0] powerOutputs;
   ddsp_port #(.LONG_DLY_CYC(20), .SHORT_DLY_CYC(10), .SG_DLY_CYC(5)) i_ddsp_port (
      .mclk(mclk), .resetn(resetn), .csN(csN), .sclk(sclk), .readNotWrite(readNotWrite),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .driveInputsN(driveInputsN),
      .overTempSense(overTempSense), .overCurrentHi(overCurrentHi),
      .overCurrentLo(overCurrentLo), .lowLoadCmp(lowLoadCmp), .groundShortCmp(groundShortCmp),
      .powerOutputs(powerOutputs), .testMode(testMode), .currentLimitSelect(currentLimitSelect));
   ddsp_host i_ddsp_host (.csN(csN), .sclk(sclk), .readNotWrite(readNotWrite),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
   initial forever #2.5 mclk = ~mclk;
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   task automatic note(input int kind, input logic [23:0] e);
      notes.push_back('{kind, e});
      #1;
      ->look;
      @(posedge mclk);
   endtask : note
   task automatic wrMode(input logic [5:0] m);
      v = $random(seed);
      i_ddsp_host.frame(1'b0, 8, {v[1:0], m});
      cyc(4);
      note(1, 24'(m[5:4]));
   endtask : wrMode
   // bit 0 read first is the summary of bits 21..1
   task automatic rdDiag(input logic [21:0] d);
      i_ddsp_host.frame(1'b1, 24, 8'h00);
      note(0, {2'b00, d[21:1], |d[21:1]});
   endtask : rdDiag
   task automatic cmpWord(input logic [23:0] e, input logic [23:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED read word exp %h got %h", e, g);
      end
   endtask : cmpWord
   task automatic cmpMode(input logic [3:0] e, input logic [3:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED mode exp %h got %h", e, g);
      end
   endtask : cmpMode
   task automatic cmpOuts(input logic [3:0] e, input logic [3:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED outputs exp %h got %h", e, g);
      end
   endtask : cmpOuts
   initial forever begin
      @(look);
      nt = notes.pop_front();
      if (nt.kind == 0) begin
         cmpWord(nt.exp, i_ddsp_host.rdWord);
      end else if (nt.kind == 1) begin
         cmpMode(nt.exp[3:0], {2'b00, testMode, currentLimitSelect});
      end else begin
         cmpOuts(nt.exp[3:0], powerOutputs);
      end
   end
   task automatic results;
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   initial begin
      #100000;
      num_errors++;
      results();
   end
   initial begin
      cyc(4);
      resetn <= 1'b1;
      cyc(4);
      note(2, 24'h0);
      note(1, 24'h0);
      for (int i = 0; i < 3; i++) begin
         v = $random(seed);
         wrMode(v[5:0]);
      end
      wrMode(6'h00);
      v = $random(seed);
      ot = v[3:0] | 4'h1;
      sg = v[7:4] | 4'h1;
      overTempSense <= ot;
      groundShortCmp <= sg;
      cyc(40);
      rdDiag({sg, 4'h0, sg, 4'h0, 4'h0, 1'b1, 1'b0});
      overTempSense <= 4'h0;
      groundShortCmp <= 4'h0;
      cyc(10);
      rdDiag({8'h00, sg, 4'h0, 4'h0, 1'b1, 1'b0});
      rdDiag(22'h0);
      // a 15 cycle low-load pulse passes only the short delay
      for (int i = 0; i < 2; i++) begin
         wrMode({5'h00, i[0]});
         driveInputsN <= 4'he;
         cyc(10);
         lowLoadCmp <= 4'h1;
         cyc(15);
         lowLoadCmp <= 4'h0;
         note(2, 24'h1);
         rdDiag(22'(i[0]) << 6);
      end
      for (int i = 0; i < 2; i++) begin
         wrMode({1'b0, i[0], 4'h0});
         driveInputsN <= 4'h8;
         cyc(10);
         overCurrentHi <= 4'h2;
         overCurrentLo <= 2'b01;
         cyc(10);
         overCurrentHi <= 4'h0;
         overCurrentLo <= 2'b00;
         cyc(10);
         note(2, {21'h0, ~i[0], 2'b01});
         driveInputsN <= 4'hf;
         cyc(10);
         driveInputsN <= 4'h8;
         cyc(10);
         note(2, 24'h7);
         wrMode({1'b0, i[0], 4'h0});
         rdDiag(i[0] ? 22'h18 : 22'h08);
         note(1, 24'(i[0]));
      end
      wrMode(6'h3f);
      driveInputsN <= 4'h0;
      cyc(10);
      resetn <= 1'b0;
      cyc(3);
      note(2, 24'h0);
      resetn <= 1'b1;
      cyc(10);
      note(1, 24'h0);
      note(2, 24'hf);
      results();
   end
endmodule : test_driver_diag_serial_port
